// *** test/etc_pin_load.sv ***
// Loads on the timer output pads, with pull-downs on released pads
`timescale 1ns/1ns
`default_nettype none
module etc_pin_load
(
    input wire logic pin_a,
    input wire logic en_a,
    input wire logic [2:0] pin_b,
    input wire logic [2:0] en_b,
    output logic pad_a,
    output logic [2:0] pad_b
);
    // A released pad falls to its pull-down, never keeps the last level
    assign pad_a = en_a ? pin_a : 1'b0;
    assign pad_b = en_b & pin_b;
endmodule : etc_pin_load
`default_nettype wire

// *** test/etc_timer_chk.sv ***
// Port checks for the timer block, with its bind
`timescale 1ns/1ns
`default_nettype none
module etc_timer_chk
    import etc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic TIMER_TICK,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic OUT_PIN_A,
    input wire logic OUT_EN_A,
    input wire logic [2:0] OUT_PIN_B,
    input wire logic [2:0] OUT_EN_B
);
    logic [7:0] c0, c1, c2, next_c0, next_c1, next_c2;
    logic [1:0] age, next_age;
    logic wr, cmp2, pwm2, tmr2, set;
    // Shadow of the control bytes; age counts edges since they last changed
    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O && WB_SEL_I[0];
    assign cmp2 = c1[7:6] == ETC_MODE_CMP && c2[7:6] == ETC_MODE_CMP;
    assign pwm2 = c1[7:6] == ETC_MODE_PWM && c2[7:6] == ETC_MODE_PWM;
    assign tmr2 = c1[7:6] == ETC_MODE_TMR && c2[7:6] == ETC_MODE_TMR;
    assign set = age[1];
    always_comb begin
        next_c0 = (wr && WB_ADR_I == ETC_OFS_CTRL0) ? WB_DAT_I[7:0] : c0;
        next_c1 = (wr && WB_ADR_I == ETC_OFS_CTRL1) ? WB_DAT_I[7:0] : c1;
        next_c2 = (wr && WB_ADR_I == ETC_OFS_CTRL2) ? WB_DAT_I[7:0] : c2;
        next_age = (age == 2'h3) ? age : age + 2'h1;
        if (next_c0 != c0 || next_c1 != c1 || next_c2 != c2) begin
            next_age = 2'h0;
        end
    end
    always_ff @(posedge CLK_SYS) begin
        {c0, c1, c2, age} <= SYS_RST ? 26'h0 : {next_c0, next_c1, next_c2, next_age};
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_run_rise;
        $rose(c0[ETC_C0_RUN]) && cmp2;
    endsequence
    AST_ACK_LATE: assert property (s_take |=> WB_ACK_O)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_IDLE_DATA: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("read data not zero while idle");
    AST_HIGH_ZERO: assert property (WB_ACK_O && !WB_WE_I && (WB_ADR_I == ETC_OFS_CMPA_HI ||
        WB_ADR_I == ETC_OFS_CMPB_HI) |-> WB_DAT_O[31:2] == 30'h0)
        else $error("unused high compare bits not zero");
    AST_RUN_INIT: assert property (s_run_rise |=> OUT_PIN_A == (c1[ETC_CH_OC] ^ c1[ETC_CH_POL]) &&
        OUT_PIN_B == {3{c2[ETC_CH_OC] ^ c2[ETC_CH_POL]}})
        else $error("pins not at initial level after run start");
    AST_TMR_FREE: assert property (set && tmr2 |-> !OUT_EN_A && OUT_EN_B == 3'h0)
        else $error("pins driven in timer mode");
    AST_PWM_NO_A: assert property (set && pwm2 && c1[ETC_C1_CLR] |-> !OUT_EN_A)
        else $error("pin a driven in pwm with clear on a");
    AST_B_MASK: assert property (set |-> (OUT_EN_B & ~c0[6:4]) == 3'h0)
        else $error("b pin driven while not enabled");
    AST_B_SAME: assert property (OUT_PIN_B == {3{OUT_PIN_B[0]}})
        else $error("b pins differ");
    AST_CMP_HOLD: assert property (set && cmp2 && !c0[ETC_C0_RUN] |->
        $stable(OUT_PIN_A) && $stable(OUT_PIN_B))
        else $error("pin moved while stopped");
endmodule : etc_timer_chk
bind etc_timer etc_timer_chk i_chk (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .TIMER_TICK(TIMER_TICK),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .OUT_PIN_A(OUT_PIN_A),
    .OUT_EN_A(OUT_EN_A), .OUT_PIN_B(OUT_PIN_B), .OUT_EN_B(OUT_EN_B));
`default_nettype wire

// *** test/tb.sv ***
// Self-checking bench for the timer compare and PWM block
`timescale 1ns/1ns
`default_nettype none
module tb
    import etc_pkg::*;
();
    typedef struct packed {
        logic [7:0] adr;
        logic [7:0] wd;
        logic [7:0] exp;
    } etc_row_t;
    logic clk_sys = 1'b0, sys_rst = 1'b1, tick = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rd, cnt0;
    logic ack, pin_a, en_a, pad_a;
    logic [2:0] pin_b, en_b, pad_b;
    int fail_count = 0, checks_done = 0, cycles = 0, ha, hb;
    etc_row_t rows [6] = '{'{ETC_OFS_CMPA_LO, 8'hA5, 8'hA5}, '{ETC_OFS_CMPA_HI, 8'hFF, 8'h03},
        '{ETC_OFS_CMPB_LO, 8'h5A, 8'h5A}, '{ETC_OFS_CMPB_HI, 8'hFE, 8'h02},
        '{8'h40, 8'hFF, 8'h00}, '{ETC_OFS_COUNT, 8'hFF, 8'h00}};
    logic [1:0] of_tab [3] = '{ETC_OF_PWM, ETC_OF_PWM, ETC_OF_ACTIVE};
    logic pol_tab [3] = '{1'b0, 1'b1, 1'b0};
    int hi_tab [3] = '{32, 96, 128};
    etc_timer i_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .TIMER_TICK(tick), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .OUT_PIN_A(pin_a), .OUT_EN_A(en_a), .OUT_PIN_B(pin_b), .OUT_EN_B(en_b));
    etc_pin_load i_load (.pin_a(pin_a), .en_a(en_a), .pin_b(pin_b), .en_b(en_b), .pad_a(pad_a), .pad_b(pad_b));
    // Clock and hang limit
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One classic bus cycle, held until ack, then one idle cycle
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= {24'h0, d};
        @(posedge clk_sys);
        // Only ack or the bench hang limit ends this wait
        while (ack !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_sys);
    endtask : xfer
    task automatic set_ab(input logic [9:0] a, input logic [9:0] b);
        xfer(1'b1, ETC_OFS_CMPA_LO, a[7:0]);
        xfer(1'b1, ETC_OFS_CMPA_HI, {6'h0, a[9:8]});
        xfer(1'b1, ETC_OFS_CMPB_LO, b[7:0]);
        xfer(1'b1, ETC_OFS_CMPB_HI, {6'h0, b[9:8]});
    endtask : set_ab
    // Stop, configure channels A and B, clear flags, then run
    task automatic start(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] c0);
        xfer(1'b1, ETC_OFS_CTRL0, 8'h00);
        xfer(1'b1, ETC_OFS_CTRL1, ca);
        xfer(1'b1, ETC_OFS_CTRL2, cb);
        xfer(1'b1, ETC_OFS_FLAGS, 8'h07);
        xfer(1'b1, ETC_OFS_CTRL0, c0);
    endtask : start
    function automatic logic [7:0] cfg(input logic [1:0] m, input logic [1:0] f, input logic oc,
        input logic pol, input logic [1:0] lo);
        return {m, f, oc, pol, lo};
    endfunction : cfg
    task automatic measure(input int n);
        ha = 0;
        hb = 0;
        repeat (n) begin
            @(posedge clk_sys);
            ha += int'(pad_a);
            hb += int'(pad_b[0]);
        end
    endtask : measure
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    // Main sequence: reset, register table, then the hand-written cases
    initial begin
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        chk("outputs", {24'h0, en_b, pin_b, en_a, pin_a}, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b0, 8'(i * 4), 8'h00);
            chk("compare reset", rd, 32'h0);
        end
        foreach (rows[i]) begin
            xfer(1'b1, rows[i].adr, rows[i].wd);
            xfer(1'b0, rows[i].adr, 8'h00);
            chk("readback", rd, {24'h0, rows[i].exp});
        end
        $display("reset and registers done");
        set_ab(10'd3, 10'd5);
        start(cfg(ETC_MODE_CMP, ETC_OF_HIGH, 1'b0, 1'b0, 2'b00),
            cfg(ETC_MODE_CMP, ETC_OF_TOGGLE, 1'b1, 1'b0, 2'b00), 8'h79);
        repeat (10) @(posedge clk_sys);
        chk("pin a", pad_a, 1'b1);
        chk("pins b", pad_b, 3'b000);
        xfer(1'b0, ETC_OFS_FLAGS, 8'h00);
        chk("flags", rd, 32'h3);
        repeat (128) @(posedge clk_sys);
        chk("pins b", pad_b, 3'b111);
        chk("pin a", pad_a, 1'b1);
        xfer(1'b0, ETC_OFS_FLAGS, 8'h00);
        chk("flags", rd, 32'h7);
        xfer(1'b1, ETC_OFS_FLAGS, 8'h07);
        xfer(1'b0, ETC_OFS_FLAGS, 8'h00);
        chk("flags", rd, 32'h0);
        tick <= 1'b0;
        xfer(1'b0, ETC_OFS_COUNT, 8'h00);
        cnt0 = rd;
        repeat (5) @(posedge clk_sys);
        xfer(1'b0, ETC_OFS_COUNT, 8'h00);
        chk("count", rd, cnt0);
        xfer(1'b1, ETC_OFS_CTRL0, 8'h71);
        xfer(1'b1, ETC_OFS_CTRL0, 8'h79);
        chk("pin a", pad_a, 1'b0);
        chk("pins b", pad_b, 3'b111);
        tick <= 1'b1;
        $display("compare clear on p done");
        set_ab(10'd200, 10'd5);
        start(cfg(ETC_MODE_CMP, ETC_OF_TOGGLE, 1'b0, 1'b0, 2'b01),
            cfg(ETC_MODE_CMP, ETC_OF_NONE, 1'b0, 1'b0, 2'b00), 8'h79);
        repeat (450) @(posedge clk_sys);
        xfer(1'b0, ETC_OFS_FLAGS, 8'h00);
        chk("flags", rd, 32'h3);
        chk("pin a", pad_a, 1'b0);
        xfer(1'b0, ETC_OFS_COUNT, 8'h00);
        chk("count", 32'(rd < 32'd200), 32'h1);
        $display("compare clear on a done");
        set_ab(10'd3, 10'd5);
        start(cfg(ETC_MODE_TMR, ETC_OF_HIGH, 1'b0, 1'b0, 2'b00),
            cfg(ETC_MODE_TMR, ETC_OF_HIGH, 1'b0, 1'b0, 2'b00), 8'h79);
        repeat (10) @(posedge clk_sys);
        chk("enables", {en_b, en_a}, 32'h0);
        xfer(1'b0, ETC_OFS_FLAGS, 8'h00);
        chk("flags", rd, 32'h3);
        $display("timer mode done");
        // Duty equal to the 128 period: full output, and B still matches
        set_ab(10'd32, 10'd128);
        for (int i = 0; i < 3; i++) begin
            start(cfg(ETC_MODE_PWM, of_tab[i], 1'b1, pol_tab[i], 2'b00),
                cfg(ETC_MODE_PWM, ETC_OF_PWM, 1'b1, 1'b0, ETC_ALIGN_EDGE), 8'h79);
            repeat (140) @(posedge clk_sys);
            measure(128);
            chk("pwm a", ha, hi_tab[i]);
            chk("pwm b", hb, 32'd128);
        end
        xfer(1'b0, ETC_OFS_FLAGS, 8'h00);
        chk("flags", rd, 32'h7);
        set_ab(10'd100, 10'd25);
        start(cfg(ETC_MODE_PWM, ETC_OF_PWM, 1'b1, 1'b0, 2'b01),
            cfg(ETC_MODE_PWM, ETC_OF_PWM, 1'b1, 1'b0, 2'b00), 8'h79);
        repeat (120) @(posedge clk_sys);
        measure(100);
        chk("pwm b", hb, 32'd25);
        chk("enable a", en_a, 1'b0);
        // Centre: up to 99 and back, 198 cycles; duty twice 25 less one
        start(cfg(ETC_MODE_PWM, ETC_OF_PWM, 1'b1, 1'b0, 2'b01),
            cfg(ETC_MODE_PWM, ETC_OF_PWM, 1'b1, 1'b0, ETC_ALIGN_BOTH), 8'h79);
        repeat (50) @(posedge clk_sys);
        measure(198);
        chk("pwm b centre", hb, 32'd49);
        $display("pwm done");
        close_out();
    end
endmodule : tb
`default_nettype wire

// *** verilog/etc_chan_out.sv ***
// Output stage of one timer channel: compare actions and PWM level
`timescale 1ns/1ns
`default_nettype none
module etc_chan_out
    import etc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire etc_chan_cfg_t cfg,
    input wire logic cmp_mode,
    input wire logic pwm_mode,
    input wire logic match,
    input wire logic run_rise,
    input wire logic pwm_active,
    output logic pin
);

    logic st;
    logic next_st;
    logic next_pin;

    // Next channel level before polarity
    always_comb begin
        next_st = st;
        if (run_rise && cmp_mode) begin
            next_st = cfg.output_control;
        end else if (cmp_mode && match) begin
            unique case (cfg.outfunc)
                ETC_OF_LOW: next_st = 1'b0;
                ETC_OF_HIGH: next_st = 1'b1;
                ETC_OF_TOGGLE: next_st = ~st;
                ETC_OF_NONE: next_st = st;
            endcase
        end else if (pwm_mode) begin
            // Active level picked by output control, forced or PWM
            if (cfg.outfunc == ETC_OF_PWM) begin
                next_st = pwm_active ? cfg.output_control : ~cfg.output_control;
            end else if (cfg.outfunc == ETC_OF_ACTIVE) begin
                next_st = cfg.output_control;
            end else begin
                next_st = ~cfg.output_control;
            end
        end
        next_pin = next_st ^ cfg.polarity;
    end

    // Level and pin registers
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= 1'b0;
            pin <= 1'b0;
        end else begin
            st <= next_st;
            pin <= next_pin;
        end
    end

endmodule : etc_chan_out
`default_nettype wire

// *** verilog/etc_pkg.sv ***
// Package for the enhanced timer compare and PWM block: offsets, fields, types
package etc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ETC_OFS_CMPA_LO = 8'h00;
    localparam logic [7:0] ETC_OFS_CMPA_HI = 8'h04;
    localparam logic [7:0] ETC_OFS_CMPB_LO = 8'h08;
    localparam logic [7:0] ETC_OFS_CMPB_HI = 8'h0C;
    localparam logic [7:0] ETC_OFS_CTRL0 = 8'h10;
    localparam logic [7:0] ETC_OFS_CTRL1 = 8'h14;
    localparam logic [7:0] ETC_OFS_CTRL2 = 8'h18;
    localparam logic [7:0] ETC_OFS_FLAGS = 8'h1C;
    localparam logic [7:0] ETC_OFS_COUNT = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ETC_C0_PER_LSB = 0;
    localparam int ETC_C0_RUN = 3;
    localparam int ETC_C0_BPIN_LSB = 4;
    localparam int ETC_CH_MODE_LSB = 6;
    localparam int ETC_CH_OUTF_LSB = 4;
    localparam int ETC_CH_OC = 3;
    localparam int ETC_CH_POL = 2;
    localparam int ETC_C1_CLR = 0;
    localparam int ETC_C2_ALIGN_LSB = 0;
    localparam int ETC_FLAG_A = 0;
    localparam int ETC_FLAG_B = 1;
    localparam int ETC_FLAG_P = 2;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] ETC_RST_BYTE = 8'h00;
    localparam logic [9:0] ETC_RST_CMP = 10'h000;
    localparam logic [2:0] ETC_RST_FLAGS = 3'h0;
    localparam logic [10:0] ETC_FULL_PERIOD = 11'h400;
    localparam int ETC_PER_SHIFT = 7;

    // ------------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ETC_MODE_CMP = 2'b00,
        ETC_MODE_CAP = 2'b01,
        ETC_MODE_PWM = 2'b10,
        ETC_MODE_TMR = 2'b11
    } etc_mode_t;

    typedef enum logic [1:0] {
        ETC_ALIGN_EDGE = 2'b00,
        ETC_ALIGN_UP = 2'b01,
        ETC_ALIGN_DOWN = 2'b10,
        ETC_ALIGN_BOTH = 2'b11
    } etc_align_t;

    localparam logic [1:0] ETC_OF_NONE = 2'b00;
    localparam logic [1:0] ETC_OF_LOW = 2'b01;
    localparam logic [1:0] ETC_OF_HIGH = 2'b10;
    localparam logic [1:0] ETC_OF_TOGGLE = 2'b11;
    localparam logic [1:0] ETC_OF_INACTIVE = 2'b00;
    localparam logic [1:0] ETC_OF_ACTIVE = 2'b01;
    localparam logic [1:0] ETC_OF_PWM = 2'b10;

    // Per-channel output configuration
    typedef struct packed {
        etc_mode_t mode;
        logic [1:0] outfunc;
        logic output_control;
        logic polarity;
    } etc_chan_cfg_t;

endpackage : etc_pkg

// *** verilog/etc_timer.sv ***
// Ten-bit enhanced timer with three comparators, compare output and PWM
// Functional notes
// - Compare value A is 10 bits, low byte plus two high bits, rest read zero.
// - Compare value B is 10 bits, low byte plus two high bits, all reset zero.
// - Mode 00 is compare output; counter clears by overflow, A or P match.
// - Clear select low: clear on P match or overflow if period zero; A, B and P flags.
// - Clear select high: clear on A match, A and B flags, never P flag.
// - Compare mode pins change only on their own channel match flag or a run bit rising edge.
// - On match a pin goes high, low or toggles; 00 leaves it alone.
// - In compare mode, run bit rising edge sets each pin to its initial level.
// - Mode 11 behaves as compare mode but drives no pins.
// - PWM with clear select high: A sets period, B duty, B pins only.
// - Edge aligned pulses start at counter zero; centre aligned counts up and down.
// - PWM raises separate A, B and P match flags.
// - Output control picks active level, output function forces or enables, polarity inverts.
// - Duty at or above period gives full active output.
// - B result drives the three B pins, A result only the A pin.
`timescale 1ns/1ns
`default_nettype none
module etc_timer
    import etc_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic TIMER_TICK,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic OUT_PIN_A,
    output logic OUT_EN_A,
    output logic [2:0] OUT_PIN_B,
    output logic [2:0] OUT_EN_B
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [9:0] compare_value_a, next_compare_value_a;
    logic [9:0] compare_value_b, next_compare_value_b;
    logic [2:0] period_field, next_period_field;
    logic timer_run, next_timer_run;
    logic run_q, next_run_q;
    logic [2:0] bpin_en, next_bpin_en;
    etc_chan_cfg_t cfg_a, next_cfg_a;
    etc_chan_cfg_t cfg_b, next_cfg_b;
    logic clear_select, next_clear_select;
    etc_align_t align_sel, next_align_sel;
    logic [2:0] flags, next_flags;
    logic [9:0] cnt, next_cnt;
    logic down, next_down;
    logic ack, next_ack;
    logic [31:0] rdata, next_rdata;
    logic en_a, next_en_a;
    logic [2:0] en_b, next_en_b;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic bus_req, wr_lo;
    logic run_rise;
    logic modes_same, cmp_mode, tmr_mode, pwm_mode, centre;
    logic [10:0] top, cnt_up;
    logic step, wrap, hit_a, hit_b, dir_ok;
    logic ev_a, ev_b, ev_p;
    logic act_a, act_b;
    logic pin_a, pin_b;

    assign bus_req = WB_CYC_I && WB_STB_I && !ack;
    assign wr_lo = bus_req && WB_WE_I && WB_SEL_I[0];
    assign run_rise = timer_run && !run_q;
    assign modes_same = (cfg_a.mode == cfg_b.mode);
    assign cmp_mode = modes_same && (cfg_a.mode == ETC_MODE_CMP);
    assign tmr_mode = modes_same && (cfg_a.mode == ETC_MODE_TMR);
    assign pwm_mode = modes_same && (cfg_a.mode == ETC_MODE_PWM);
    assign centre = pwm_mode && (align_sel != ETC_ALIGN_EDGE);
    assign step = timer_run && !run_rise && TIMER_TICK;
    assign cnt_up = {1'b0, cnt} + 11'h001;

    // Counter top: compare A or the period field in steps of 128
    always_comb begin
        if (clear_select) begin
            top = (compare_value_a == ETC_RST_CMP) ? ETC_FULL_PERIOD : {1'b0, compare_value_a};
        end else if (period_field == 3'h0) begin
            top = ETC_FULL_PERIOD;
        end else begin
            top = {1'b0, period_field, 7'h00};
        end
    end

    // Counter stepping and comparator events
    always_comb begin
        next_cnt = cnt;
        next_down = down;
        wrap = 1'b0;
        hit_a = 1'b0;
        hit_b = 1'b0;
        dir_ok = 1'b1;
        ev_p = 1'b0;
        if (run_rise) begin
            next_cnt = 10'h000;
            next_down = 1'b0;
        end else if (step && !centre) begin
            wrap = (cnt_up == top);
            next_cnt = wrap ? 10'h000 : cnt_up[9:0];
            hit_a = (cnt_up[9:0] == compare_value_a);
            hit_b = (cnt_up[9:0] == compare_value_b);
            ev_p = wrap && !clear_select;
        end else if (step) begin
            // Centre mode counts up to top less one, then back to zero
            if (!down) begin
                next_cnt = cnt_up[9:0];
                next_down = (cnt_up >= top - 11'h001);
                dir_ok = (align_sel != ETC_ALIGN_DOWN);
            end else begin
                next_cnt = cnt - 10'h001;
                next_down = (cnt != 10'h001);
                dir_ok = (align_sel != ETC_ALIGN_UP);
                ev_p = (cnt == 10'h001) && !clear_select;
            end
            hit_a = (next_cnt == compare_value_a) && dir_ok;
            hit_b = (next_cnt == compare_value_b) && dir_ok;
        end
        ev_a = hit_a && (cmp_mode || tmr_mode || pwm_mode);
        ev_b = hit_b && (cmp_mode || tmr_mode || pwm_mode);
    end

    // PWM active phase per channel
    always_comb begin
        act_a = ({1'b0, compare_value_a} >= top) || (cnt < compare_value_a);
        act_b = ({1'b0, compare_value_b} >= top) || (cnt < compare_value_b);
    end

    // ------------------------------------------------------------------
    // Registers, flags and bus
    // ------------------------------------------------------------------

    // Next values for software state and bus answer
    always_comb begin
        next_compare_value_a = compare_value_a;
        next_compare_value_b = compare_value_b;
        next_period_field = period_field;
        next_timer_run = timer_run;
        next_bpin_en = bpin_en;
        next_cfg_a = cfg_a;
        next_cfg_b = cfg_b;
        next_clear_select = clear_select;
        next_align_sel = align_sel;
        next_flags = flags;
        next_run_q = timer_run;
        next_ack = bus_req;
        next_rdata = 32'h0000_0000;
        if (wr_lo) begin
            unique case (WB_ADR_I)
                ETC_OFS_CMPA_LO: next_compare_value_a[7:0] = WB_DAT_I[7:0];
                ETC_OFS_CMPA_HI: next_compare_value_a[9:8] = WB_DAT_I[1:0];
                ETC_OFS_CMPB_LO: next_compare_value_b[7:0] = WB_DAT_I[7:0];
                ETC_OFS_CMPB_HI: next_compare_value_b[9:8] = WB_DAT_I[1:0];
                ETC_OFS_CTRL0: begin
                    next_period_field = WB_DAT_I[ETC_C0_PER_LSB +: 3];
                    next_timer_run = WB_DAT_I[ETC_C0_RUN];
                    next_bpin_en = WB_DAT_I[ETC_C0_BPIN_LSB +: 3];
                end
                ETC_OFS_CTRL1: begin
                    next_cfg_a = etc_chan_cfg_t'(WB_DAT_I[7:2]);
                    next_clear_select = WB_DAT_I[ETC_C1_CLR];
                end
                ETC_OFS_CTRL2: begin
                    next_cfg_b = etc_chan_cfg_t'(WB_DAT_I[7:2]);
                    next_align_sel = etc_align_t'(WB_DAT_I[ETC_C2_ALIGN_LSB +: 2]);
                end
                ETC_OFS_FLAGS: next_flags = flags & ~WB_DAT_I[2:0];
                default: next_flags = flags;
            endcase
        end
        // Hardware set wins over a software clear
        next_flags[ETC_FLAG_A] = next_flags[ETC_FLAG_A] | ev_a;
        next_flags[ETC_FLAG_B] = next_flags[ETC_FLAG_B] | ev_b;
        next_flags[ETC_FLAG_P] = next_flags[ETC_FLAG_P] | (ev_p && (pwm_mode || cmp_mode || tmr_mode));
        if (bus_req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                ETC_OFS_CMPA_LO: next_rdata[7:0] = compare_value_a[7:0];
                ETC_OFS_CMPA_HI: next_rdata[1:0] = compare_value_a[9:8];
                ETC_OFS_CMPB_LO: next_rdata[7:0] = compare_value_b[7:0];
                ETC_OFS_CMPB_HI: next_rdata[1:0] = compare_value_b[9:8];
                ETC_OFS_CTRL0: next_rdata[6:0] = {bpin_en, timer_run, period_field};
                ETC_OFS_CTRL1: next_rdata[7:0] = {cfg_a, 1'b0, clear_select};
                ETC_OFS_CTRL2: next_rdata[7:0] = {cfg_b, align_sel};
                ETC_OFS_FLAGS: next_rdata[2:0] = flags;
                ETC_OFS_COUNT: next_rdata[9:0] = cnt;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        // Pin drive enables per mode
        next_en_a = cmp_mode || (pwm_mode && !clear_select);
        next_en_b = (cmp_mode || pwm_mode) ? bpin_en : 3'h0;
    end

    // Register all state
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            compare_value_a <= ETC_RST_CMP;
            compare_value_b <= ETC_RST_CMP;
            period_field <= 3'h0;
            timer_run <= 1'b0;
            run_q <= 1'b0;
            bpin_en <= 3'h0;
            cfg_a <= etc_chan_cfg_t'(6'h00);
            cfg_b <= etc_chan_cfg_t'(6'h00);
            clear_select <= 1'b0;
            align_sel <= ETC_ALIGN_EDGE;
            flags <= ETC_RST_FLAGS;
            cnt <= 10'h000;
            down <= 1'b0;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            en_a <= 1'b0;
            en_b <= 3'h0;
        end else begin
            compare_value_a <= next_compare_value_a;
            compare_value_b <= next_compare_value_b;
            period_field <= next_period_field;
            timer_run <= next_timer_run;
            run_q <= next_run_q;
            bpin_en <= next_bpin_en;
            cfg_a <= next_cfg_a;
            cfg_b <= next_cfg_b;
            clear_select <= next_clear_select;
            align_sel <= next_align_sel;
            flags <= next_flags;
            cnt <= next_cnt;
            down <= next_down;
            ack <= next_ack;
            rdata <= next_rdata;
            en_a <= next_en_a;
            en_b <= next_en_b;
        end
    end

    // ------------------------------------------------------------------
    // Output stages
    // ------------------------------------------------------------------

    // Channel A follows only the A event
    etc_chan_out u_out_a (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .cfg(cfg_a),
        .cmp_mode(cmp_mode),
        .pwm_mode(pwm_mode && !clear_select),
        .match(ev_a),
        .run_rise(run_rise),
        .pwm_active(act_a),
        .pin(pin_a)
    );

    // Channel B follows only the B event
    etc_chan_out u_out_b (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .cfg(cfg_b),
        .cmp_mode(cmp_mode),
        .pwm_mode(pwm_mode),
        .match(ev_b),
        .run_rise(run_rise),
        .pwm_active(act_b),
        .pin(pin_b)
    );

    // Port drive from flip-flops
    assign OUT_PIN_A = pin_a;
    assign OUT_PIN_B = {3{pin_b}};
    assign OUT_EN_A = en_a;
    assign OUT_EN_B = en_b;
    assign WB_ACK_O = ack;
    assign WB_DAT_O = rdata;

endmodule : etc_timer
`default_nettype wire
